// *** ivmap_pkg.sv ***
// Package with the request map, vector table layout and carrier structs.
package ivmap_pkg;

  localparam int NUM_REQ = 118;
  localparam int REQ_W = 7;
  localparam int ADDR_W = 24;
  localparam logic [REQ_W-1:0] VECTOR_BASE = 7'h08;
  localparam logic [ADDR_W-1:0] RESET_ADDR = 24'h000000;
  localparam logic [ADDR_W-1:0] PRIMARY_BASE = 24'h000014;
  localparam logic [ADDR_W-1:0] ALT_OFFSET = 24'h000100;
  localparam logic [NUM_REQ-1:0] RESET_PENDING = '0;

  // Request numbers of the named sources.
  localparam int RQ_EXT0 = 0;
  localparam int RQ_CAP1 = 1;
  localparam int RQ_CMPU1 = 2;
  localparam int RQ_TMR1 = 3;
  localparam int RQ_DMA0 = 4;
  localparam int RQ_CAP2 = 5;
  localparam int RQ_CMPU2 = 6;
  localparam int RQ_TMR2 = 7;
  localparam int RQ_TMR3 = 8;
  localparam int RQ_SPI1_FAULT = 9;
  localparam int RQ_SPI1_DONE = 10;
  localparam int RQ_SER1_RX = 11;
  localparam int RQ_SER1_TX = 12;
  localparam int RQ_ADC_GROUP = 13;
  localparam int RQ_DMA1 = 14;
  localparam int RQ_TW1_SLAVE = 16;
  localparam int RQ_TW1_MASTER = 17;
  localparam int RQ_ACMP1 = 18;
  localparam int RQ_PIN_CHANGE = 19;
  localparam int RQ_EXT1 = 20;
  localparam int RQ_DMA2 = 24;
  localparam int RQ_CMPU3 = 25;
  localparam int RQ_CMPU4 = 26;
  localparam int RQ_TMR4 = 27;
  localparam int RQ_TMR5 = 28;
  localparam int RQ_EXT2 = 29;
  localparam int RQ_SER2_RX = 30;
  localparam int RQ_SER2_TX = 31;
  localparam int RQ_SPI2_ERR = 32;
  localparam int RQ_SPI2_DONE = 33;
  localparam int RQ_CAN_RX = 34;
  localparam int RQ_CAN_EVENT = 35;
  localparam int RQ_DMA3 = 36;
  localparam int RQ_CAP3 = 37;
  localparam int RQ_CAP4 = 38;
  localparam int RQ_TW2_SLAVE = 49;
  localparam int RQ_TW2_MASTER = 50;
  localparam int RQ_EXT3 = 53;
  localparam int RQ_EXT4 = 54;
  localparam int RQ_PWM_SPECIAL = 57;
  localparam int RQ_ENC1 = 58;
  localparam int RQ_SER1_ERR = 65;
  localparam int RQ_SER2_ERR = 66;
  localparam int RQ_CAN_TX = 70;
  localparam int RQ_PWM_SEC_SPECIAL = 73;
  localparam int RQ_ENC2 = 75;
  localparam int RQ_ADC_PAIR8 = 81;
  localparam int RQ_PWM_GEN0 = 94;
  localparam int RQ_ACMP2 = 103;
  localparam int RQ_ADC_PAIR0 = 110;

  localparam int N_PWM = 9;
  localparam int N_ADC_LO = 8;
  localparam int N_ADC_HI = 5;
  localparam int N_ACMP_HI = 3;

  // Source bundles grouped by peripheral family.
  typedef struct packed {
    logic [4:0] ext_pin;
    logic [3:0] dma_done;
    logic [4:0] timer;
    logic [3:0] capture;
    logic [3:0] compare;
    logic [3:0] comparator;
    logic [N_PWM-1:0] pwm_gen;
    logic [12:0] adc_pair;
    logic adc_group;
  } src_a_s;

  typedef struct packed {
    logic [1:0] serial_rx;
    logic [1:0] serial_tx;
    logic [1:0] serial_err;
    logic [1:0] spi_fault;
    logic [1:0] spi_done;
    logic [1:0] twowire_slave;
    logic [1:0] twowire_master;
    logic can_rx_ready;
    logic can_event;
    logic can_tx_request;
    logic pwm_special;
    logic pwm_sec_special;
    logic pin_change;
    logic [1:0] encoder_compare;
  } src_b_s;

  // Answer presented to the core.
  typedef struct packed {
    logic valid;
    logic [REQ_W-1:0] request_number;
    logic [REQ_W-1:0] vector_number;
    logic [ADDR_W-1:0] table_addr;
  } vec_out_s;

endpackage : ivmap_pkg

// *** req_picker.sv ***
// Fixed natural-order priority picker: lowest pending request wins.
module req_picker
  import ivmap_pkg::*;
#(
  parameter int N = NUM_REQ,
  parameter int W = REQ_W
) (
  input wire logic [N-1:0] pending,
  output logic any,
  output logic [W-1:0] winner
);

  // Scan from the top down so the lowest number is left standing.
  always_comb begin
    any = 1'b0;
    winner = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pending[i]) begin // R7
        any = 1'b1;
        winner = W'(i);
      end
    end
  end

endmodule : req_picker

// *** interrupt_vector_map.sv ***
// Maps source requests to vector numbers and handler table addresses.
//
// Summary of operation
// R1: Reset clears state; reset start address presented is zero.
// R2: Reset is never arbitrated or given a vector slot.
// R3: Firmware fills unused slots with a default handler that resets.
// R4: Vector number equals request number plus eight.
// R5: Primary entry address is 0x000014 plus twice the request number.
// R6: Alternate entry sits 0x100 above the primary entry.
// R7: Lowest request number wins; priority falls as number rises.
// R8: External pins zero to four use requests 0, 20, 29, 53, 54.
// R9: Transfer channel completions use requests 4, 14, 24, 36.
// R10: Converter pairs 8-12 use 81-85, pairs 0-7 from 110, group 13.
// R11: Nine pulse-width generators use requests 94 through 102 in order.
// R12: Comparator one uses 18, comparators two to four use 103-105.
// R13: Serial ports use 11, 12, 65 and 30, 31, 66.
// R14: Two-wire units use 16, 17 and 49, 50.
// R15: Bus controller uses 34 receive, 35 event, 70 transmit request.
// R16: Timers 3,7,8,27,28; captures 1,5,37,38; compares 2,6,25,26.
// R17: Special event 57, secondary special event 73, pin change 19.
// R18: Encoder compares use requests 58 and 75.
// R19: With alternate select set, every fetch uses the alternate table.
// R20: Each table entry holds a 24-bit handler start address.
// R21: Reserved requests never assert; only the winner is presented.
module interrupt_vector_map
  import ivmap_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire src_a_s src_a,
  input wire src_b_s src_b,
  input wire logic [NUM_REQ-1:0] enable_mask,
  input wire logic alt_table_select,
  input wire logic ack,
  output vec_out_s vec_out,
  output logic [ADDR_W-1:0] reset_fetch_addr
);

  ////////////////////////////////////////////////////////////////////////////
  // Address arithmetic shared by the output stage.

  // Table word address of a request in the chosen table.
  function automatic logic [ADDR_W-1:0] entry_addr(
    input logic [REQ_W-1:0] rq,
    input logic alt
  );
    logic [ADDR_W-1:0] a;
    a = PRIMARY_BASE + {16'h0000, rq, 1'b0}; // R5
    if (alt) begin
      a = a + ALT_OFFSET; // R6 R19
    end
    return a; // R20
  endfunction : entry_addr

  ////////////////////////////////////////////////////////////////////////////
  // Source to request number map.

  logic [NUM_REQ-1:0] req_vec;

  // Each source lands on its fixed request line; the rest stay low.
  always_comb begin
    req_vec = '0; // R21
    req_vec[RQ_EXT0] = src_a.ext_pin[0]; // R8
    req_vec[RQ_EXT1] = src_a.ext_pin[1]; // R8
    req_vec[RQ_EXT2] = src_a.ext_pin[2]; // R8
    req_vec[RQ_EXT3] = src_a.ext_pin[3]; // R8
    req_vec[RQ_EXT4] = src_a.ext_pin[4]; // R8
    req_vec[RQ_DMA0] = src_a.dma_done[0]; // R9
    req_vec[RQ_DMA1] = src_a.dma_done[1]; // R9
    req_vec[RQ_DMA2] = src_a.dma_done[2]; // R9
    req_vec[RQ_DMA3] = src_a.dma_done[3]; // R9
    req_vec[RQ_ADC_GROUP] = src_a.adc_group; // R10
    for (int i = 0; i < N_ADC_LO; i++) begin
      req_vec[RQ_ADC_PAIR0 + i] = src_a.adc_pair[i]; // R10
    end
    for (int i = 0; i < N_ADC_HI; i++) begin
      req_vec[RQ_ADC_PAIR8 + i] = src_a.adc_pair[N_ADC_LO + i]; // R10
    end
    for (int i = 0; i < N_PWM; i++) begin
      req_vec[RQ_PWM_GEN0 + i] = src_a.pwm_gen[i]; // R11
    end
    req_vec[RQ_ACMP1] = src_a.comparator[0]; // R12
    for (int i = 0; i < N_ACMP_HI; i++) begin
      req_vec[RQ_ACMP2 + i] = src_a.comparator[1 + i]; // R12
    end
    req_vec[RQ_SER1_RX] = src_b.serial_rx[0]; // R13
    req_vec[RQ_SER1_TX] = src_b.serial_tx[0]; // R13
    req_vec[RQ_SER1_ERR] = src_b.serial_err[0]; // R13
    req_vec[RQ_SER2_RX] = src_b.serial_rx[1]; // R13
    req_vec[RQ_SER2_TX] = src_b.serial_tx[1]; // R13
    req_vec[RQ_SER2_ERR] = src_b.serial_err[1]; // R13
    req_vec[RQ_SPI1_FAULT] = src_b.spi_fault[0];
    req_vec[RQ_SPI1_DONE] = src_b.spi_done[0];
    req_vec[RQ_SPI2_ERR] = src_b.spi_fault[1];
    req_vec[RQ_SPI2_DONE] = src_b.spi_done[1];
    req_vec[RQ_TW1_SLAVE] = src_b.twowire_slave[0]; // R14
    req_vec[RQ_TW1_MASTER] = src_b.twowire_master[0]; // R14
    req_vec[RQ_TW2_SLAVE] = src_b.twowire_slave[1]; // R14
    req_vec[RQ_TW2_MASTER] = src_b.twowire_master[1]; // R14
    req_vec[RQ_CAN_RX] = src_b.can_rx_ready; // R15
    req_vec[RQ_CAN_EVENT] = src_b.can_event; // R15
    req_vec[RQ_CAN_TX] = src_b.can_tx_request; // R15
    req_vec[RQ_TMR1] = src_a.timer[0]; // R16
    req_vec[RQ_TMR2] = src_a.timer[1]; // R16
    req_vec[RQ_TMR3] = src_a.timer[2]; // R16
    req_vec[RQ_TMR4] = src_a.timer[3]; // R16
    req_vec[RQ_TMR5] = src_a.timer[4]; // R16
    req_vec[RQ_CAP1] = src_a.capture[0]; // R16
    req_vec[RQ_CAP2] = src_a.capture[1]; // R16
    req_vec[RQ_CAP3] = src_a.capture[2]; // R16
    req_vec[RQ_CAP4] = src_a.capture[3]; // R16
    req_vec[RQ_CMPU1] = src_a.compare[0]; // R16
    req_vec[RQ_CMPU2] = src_a.compare[1]; // R16
    req_vec[RQ_CMPU3] = src_a.compare[2]; // R16
    req_vec[RQ_CMPU4] = src_a.compare[3]; // R16
    req_vec[RQ_PWM_SPECIAL] = src_b.pwm_special; // R17
    req_vec[RQ_PWM_SEC_SPECIAL] = src_b.pwm_sec_special; // R17
    req_vec[RQ_PIN_CHANGE] = src_b.pin_change; // R17
    req_vec[RQ_ENC1] = src_b.encoder_compare[0]; // R18
    req_vec[RQ_ENC2] = src_b.encoder_compare[1]; // R18
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending latch: a request stays pending until the core acknowledges it.

  logic [NUM_REQ-1:0] pending_q;
  logic [NUM_REQ-1:0] pending_d;
  logic [NUM_REQ-1:0] clear_mask;
  logic win_any;
  logic [REQ_W-1:0] win_num;

  // The ack clears the presented winner; a new pulse in that cycle wins.
  always_comb begin
    clear_mask = '0;
    if (ack && vec_out.valid) begin
      clear_mask[vec_out.request_number] = 1'b1;
    end
    pending_d = (pending_q & ~clear_mask) | req_vec;
  end

  // Reset empties the pending set; reset itself never occupies a slot.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pending_q <= RESET_PENDING; // R2
    end else begin
      pending_q <= pending_d;
    end
  end

  req_picker #(
    .N(NUM_REQ),
    .W(REQ_W)
  ) u_picker (
    .pending(pending_q & enable_mask),
    .any(win_any),
    .winner(win_num)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registered answer to the core.

  vec_out_s vec_d;

  // Only the winning implemented request is presented.
  always_comb begin
    vec_d = '0;
    if (win_any) begin
      vec_d.valid = 1'b1; // R21
      vec_d.request_number = win_num;
      vec_d.vector_number = win_num + VECTOR_BASE; // R4
      vec_d.table_addr = entry_addr(win_num, alt_table_select); // R5 R19
    end
  end

  // The answer register and the reset fetch address.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vec_out <= '0;
      reset_fetch_addr <= RESET_ADDR; // R1
    end else begin
      vec_out <= vec_d;
      reset_fetch_addr <= RESET_ADDR; // R1
    end
  end

endmodule : interrupt_vector_map

// *** ivmap_props.sv ***
// Checker of the vector outputs against sources, mask and table select.
module ivmap_props
  import ivmap_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire src_a_s src_a,
  input wire src_b_s src_b,
  input wire logic [NUM_REQ-1:0] enable_mask,
  input wire logic alt_table_select,
  input wire logic ack,
  input wire vec_out_s vec_out,
  input wire logic [ADDR_W-1:0] reset_fetch_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Presented vector fields follow the request number and table choice.
  a_vector_offset: assert property (
    vec_out.valid |-> vec_out.vector_number == vec_out.request_number + 7'h08
  ) else $error("Vector number is not request plus eight.");
  a_primary_addr: assert property (
    vec_out.valid && !$past(alt_table_select) |->
    vec_out.table_addr == 24'h000014 + {vec_out.request_number, 1'b0}
  ) else $error("Primary table address is wrong.");
  a_alt_addr: assert property (
    vec_out.valid && $past(alt_table_select) |->
    vec_out.table_addr == 24'h000114 + {vec_out.request_number, 1'b0}
  ) else $error("Alternate table address is wrong.");
  a_boot_addr: assert property (
    reset_fetch_addr == 24'h000000
  ) else $error("Reset start address is not zero.");

  // Request zero outranks all and shows two edges after it is raised.
  a_first_latency: assert property (
    src_a.ext_pin[0] && enable_mask[0] && !ack ##1 enable_mask[0] && !ack
    |=> vec_out.valid && vec_out.request_number == 7'h00
  ) else $error("External request zero not presented in time.");
  a_mask_honoured: assert property (
    vec_out.valid |->
    |($past(enable_mask) & (118'h1 << vec_out.request_number))
  ) else $error("Masked request was presented.");
  a_no_reserved: assert property (
    vec_out.valid |-> vec_out.request_number < 7'h76 &&
    !(vec_out.request_number inside {7'h0F, [7'h15:7'h17], [7'h27:7'h30],
      [7'h33:7'h34], [7'h37:7'h38], [7'h3B:7'h40], [7'h43:7'h45],
      [7'h47:7'h48], 7'h4A, [7'h4C:7'h50], [7'h56:7'h5D], [7'h6A:7'h6D]})
  ) else $error("Reserved request number was presented.");
  a_reset_clear: assert property (disable iff (1'b0)
    !rstn |-> vec_out == '0
  ) else $error("Outputs not cleared during reset.");
endmodule : ivmap_props

bind interrupt_vector_map ivmap_props u_props (.clk(clk), .rstn(rstn),
  .src_a(src_a), .src_b(src_b), .enable_mask(enable_mask),
  .alt_table_select(alt_table_select), .ack(ack), .vec_out(vec_out),
  .reset_fetch_addr(reset_fetch_addr));

// *** core_model.sv ***
// Core model that takes presented vectors and loads the handler address.
module core_model
  import ivmap_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire vec_out_s vec,
  input wire logic [1:0] delay,
  output logic ack,
  output logic [ADDR_W-1:0] pc,
  output logic [REQ_W-1:0] taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] gap;
  localparam logic [ADDR_W-1:0] DEFAULT_HANDLER = 24'h000200;
  localparam logic [ADDR_W-1:0] HANDLER_OFS = 24'h001000;
  logic [ADDR_W-1:0] handler_tab [256];

  // Slot index is the entry's word address over two; tables share it.
  function automatic logic reserved_slot(input int s);
    int n;
    n = (s < 128) ? s - 10 : s - 138;
    return n < 0 || n > 117 || n inside {15, [21:23], [39:48], [51:52],
      [55:56], [59:64], [67:69], [71:72], 74, [76:80], [86:93], [106:109]};
  endfunction : reserved_slot

  // Firmware image: implemented slots point at their own handler, and the
  // reserved ones at a default handler that issues a software reset.
  initial begin
    for (int s = 0; s < 256; s++) begin
      if (reserved_slot(s)) begin
        handler_tab[s] = DEFAULT_HANDLER;
      end else begin
        handler_tab[s] = 24'(2 * s) + HANDLER_OFS;
      end
    end
  end

  // Skips the two stale cycles after a take, then waits delay cycles more.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack <= 1'b0;
      gap <= 3'h7;
      pc <= 24'h000000;
      taken <= '0;
    end else if (vec.valid && gap >= 3'(delay) + 3'h2) begin
      ack <= 1'b1;
      gap <= 3'h0;
      pc <= handler_tab[vec.table_addr[8:1]];
      taken <= vec.request_number;
    end else begin
      ack <= 1'b0;
      gap <= (gap == 3'h7) ? gap : gap + 3'h1;
    end
  end
endmodule : core_model

// *** tb_interrupt_vector_map.sv ***
// Self-checking bench for the vector map with a core model beside it.
module tb_interrupt_vector_map
  import ivmap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b1, alt_table_select = 1'b0, ack;
  logic [70:0] srcs = '0;
  logic [NUM_REQ-1:0] enable_mask = '1;
  logic [1:0] delay = 2'h0;
  vec_out_s vec_out;
  logic [ADDR_W-1:0] reset_fetch_addr, pc;
  logic [REQ_W-1:0] taken;
  int err_count = 0, checks = 0, cycles = 0;
  byte unsigned req_tab [71] = '{58, 75, 19, 73, 57, 70, 35, 34, 17, 50,
    16, 49, 10, 33, 9, 32, 65, 66, 12, 31, 11, 30, 13, 110, 111, 112, 113,
    114, 115, 116, 117, 81, 82, 83, 84, 85, 94, 95, 96, 97, 98, 99, 100,
    101, 102, 18, 103, 104, 105, 2, 6, 25, 26, 1, 5, 37, 38, 3, 7, 8, 27,
    28, 4, 14, 24, 36, 0, 20, 29, 53, 54};

  interrupt_vector_map DUT (.clk(clk), .rstn(rstn), .src_a(srcs[70:22]),
    .src_b(srcs[21:0]), .enable_mask(enable_mask), .ack(ack),
    .alt_table_select(alt_table_select), .vec_out(vec_out),
    .reset_fetch_addr(reset_fetch_addr));
  core_model core (.clk(clk), .rstn(rstn), .vec(vec_out), .delay(delay),
    .ack(ack), .pc(pc), .taken(taken));

  // Expected handler entry address for a request and table choice.
  function automatic logic [23:0] addr_of(input int rq, input logic alt);
    return 24'h000014 + 24'(2 * rq) + (alt ? 24'h000100 : 24'h000000);
  endfunction : addr_of

  // Handler that the core's firmware image plants in that entry.
  function automatic logic [23:0] handler_of(input int rq, input logic alt);
    return addr_of(rq, alt) + 24'h001000;
  endfunction : handler_of

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  // Waits a bounded time for the core to take a vector, then compares.
  task automatic expect_take(input int rq);
    int n;
    n = 0;
    while (ack !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check("ack", 1, ack);
    check("taken", rq, taken);
    check("pc", handler_of(rq, alt_table_select), pc);
    check("vector", rq + 8, vec_out.vector_number);
    @(negedge clk);
  endtask : expect_take

  task automatic pulse(input logic [70:0] v);
    @(posedge clk);
    delay <= 2'($urandom);
    srcs <= v;
    @(posedge clk);
    srcs <= '0;
  endtask : pulse

  task automatic end_of_test();
    $display("Errors %0d of %0d checks", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    forever #10 clk = ~clk;
  end

  // Cuts a hang short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      err_count++;
      end_of_test();
    end
  end

  // Main sequence: sweep, pairs, masking, mid-run reset.
  initial begin
    int i, j, rq;
    void'($urandom(70));
    rstn <= 1'b0; // A real falling edge starts the asynchronous reset.
    repeat (16) @(posedge clk);
    check("boot", 24'h000000, reset_fetch_addr);
    rstn <= 1'b1;
    for (i = 0; i < 71; i++) begin
      alt_table_select <= 1'($urandom);
      pulse(71'h1 << i);
      expect_take(req_tab[i]);
    end
    for (int k = 0; k < 15; k++) begin
      i = (k == 0) ? 66 : $urandom_range(70);
      j = (k == 0) ? 30 : $urandom_range(70);
      j = (i == j) ? (i + 1) % 71 : j;
      pulse((71'h1 << i) | (71'h1 << j));
      expect_take(req_tab[i] < req_tab[j] ? req_tab[i] : req_tab[j]);
      expect_take(req_tab[i] < req_tab[j] ? req_tab[j] : req_tab[i]);
    end
    i = $urandom_range(70);
    rq = req_tab[i];
    enable_mask[rq] <= 1'b0;
    pulse(71'h1 << i);
    repeat (6) @(negedge clk);
    check("masked", 0, vec_out.valid);
    enable_mask <= '1;
    expect_take(rq);
    pulse(71'h1 << 66);
    // Reset lands while the fresh vector is presented and not yet taken.
    @(posedge clk);
    rstn <= 1'b0;
    @(negedge clk);
    check("rst vec", 0, {vec_out.valid, vec_out.request_number,
                         vec_out.vector_number});
    check("rst addr", 0, vec_out.table_addr);
    check("rst pc", 0, pc);
    @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(negedge clk);
    check("cleared", 0, vec_out.valid);
    check("boot again", 0, reset_fetch_addr);
    end_of_test();
  end
endmodule : tb_interrupt_vector_map
